// ---- verilog/msc_pkg.sv ----
`default_nettype none
package msc_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned MS_PERIOD_NS = 1_000_000;
	localparam int unsigned MS_CYCLES_DEF = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned DEAD_DEF_S = 8;
	localparam logic [31:0] DEAD_DEF_MS = 32'(DEAD_DEF_S * 1000);
	localparam logic [31:0] HOLD_DEF_MS = 32'd50;
	localparam logic [31:0] GAZE_DEF_MS = 32'd100;
	localparam logic [31:0] DWELL_DEF_MS = 32'd0;
	localparam logic [31:0] DEAD_MAX = 32'd999999999;
	localparam logic [31:0] HOLD_MAX = 32'd999999999;
	localparam logic [31:0] GAZE_MAX = 32'd99999999;
	localparam logic [31:0] SQL_MAX = 32'd127;
	localparam logic [6:0] SQL_DEF = 7'h00;
	localparam logic [9:0] CH_FIRST = 10'd0;
	localparam logic [9:0] CH_LAST = 10'd999;
	localparam logic [4:0] ADDR_ALL = 5'h1f;
	localparam int unsigned ADDR_FLAG = 7;
	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_RSP = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_MASK = 8'h0c;
	localparam logic [7:0] REG_STATE = 8'h10;
	localparam int unsigned IRQ_ACT = 0;
	localparam int unsigned IRQ_ERR = 1;
	localparam int unsigned IRQ_RSP = 2;
	localparam int unsigned IRQ_W = 3;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ----------------------------------------------------------------
	// Characters
	// ----------------------------------------------------------------
	localparam logic [7:0] ASC_SET = 8'h2a;
	localparam logic [7:0] ASC_GET = 8'h3f;
	localparam logic [7:0] ASC_CR = 8'h0d;
	localparam logic [7:0] ASC_0 = 8'h30;
	localparam logic [7:0] ASC_9 = 8'h39;
	localparam logic [15:0] CODE_SQL = 16'h5331;
	localparam logic [15:0] CODE_STR = 16'h5333;
	localparam logic [15:0] CODE_DWELL = 16'h5431;
	localparam logic [15:0] CODE_DEAD = 16'h5432;
	localparam logic [15:0] CODE_GAZE = 16'h5433;
	localparam logic [15:0] CODE_HOLD = 16'h5434;
	localparam logic [15:0] CODE_OVR_OFF = 16'h5531;
	localparam logic [15:0] CODE_OVR_ON = 16'h5532;
	localparam logic [15:0] CODE_SCAN = 16'h5034;
	localparam logic [15:0] CODE_RESET = 16'h4339;
	localparam logic [15:0] CODE_ERR = 16'h4552;
	localparam logic [7:0] SC_ARG_START = 8'h53;
	localparam logic [7:0] SC_ARG_HALT = 8'h48;
	localparam logic [7:0] SC_ARG_PAUSE = 8'h50;
	localparam logic [7:0] SC_ARG_RESUME = 8'h52;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SC_MANUAL = 3'b000, SC_HOLD = 3'b001, SC_GAZE = 3'b011,
		SC_ACTIVE = 3'b010, SC_PAUSED = 3'b110
	} msc_scan_t;
	typedef enum logic [2:0] {
		PS_IDLE = 3'b000, PS_CODE1 = 3'b001, PS_CODE2 = 3'b011,
		PS_ARG = 3'b010, PS_REPLY = 3'b110
	} msc_parse_t;
	typedef enum logic [1:0] {
		RP_C1 = 2'b00, RP_C2 = 2'b01, RP_DIG = 2'b11, RP_CR = 2'b10
	} msc_rphase_t;
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} msc_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} msc_axi_rsp_t;
endpackage : msc_pkg
`default_nettype wire

// ---- verilog/msc_scan_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - Scan start walks channels 0 to 999 when no range is set.
// - Scan start with no programmed channel answers an error, stays manual.
// - Halt ends scanning, returns to manual, keeps current channel.
// - Pause acts only while scanning; ignored otherwise.
// - Resume acts only while paused; ignored otherwise.
// - Strength below squelch level means invalid signal and muted audio.
// - Strength query reports the same 0 to 127 value used for squelch.
// - Dwell limits time on active channel; zero means stay while squelch open.
// - Dead time holds channel after activity ends; default 8 s.
// - Smaller of dwell and dead settings decides when scanning resumes.
// - Gaze time sets how long each new channel is watched.
// - Hold-off wait after tuning before judging activity; default 50 ms.
// - Override off and all switches on: answer every command.
// - Otherwise answer only commands carrying the switch address, switch 4 MSB.
// - Override-off command hands addressing back to the switches.
// - Override-on answers all commands until override-off, reset command or power reset.
module msc_scan_ctrl #(
	parameter int unsigned MS_CYCLES = msc_pkg::MS_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire msc_pkg::msc_axi_req_t axi_req,
	output msc_pkg::msc_axi_rsp_t axi_rsp,
	output logic irq,
	input wire logic [4:0] address_switch_bank,
	input wire logic [6:0] s_meter,
	input wire logic chan_any_prog,
	output logic [9:0] scan_chan,
	output logic [2:0] scan_mode,
	output logic audio_mute
);
	import msc_pkg::*;

	typedef struct packed {
		msc_scan_t scan;
		logic [9:0] chan;
		logic [31:0] div;
		logic [31:0] tmr;
		logic [31:0] dead;
		logic mute;
		logic [6:0] sql;
		logic [31:0] dwell;
		logic [31:0] deadset;
		logic [31:0] gaze;
		logic [31:0] hold;
		logic ovr;
		msc_parse_t ps;
		logic get;
		logic [15:0] code;
		logic [7:0] argc;
		logic [31:0] val;
		logic has_addr;
		logic [4:0] addr;
		msc_rphase_t rp;
		logic [15:0] rcode;
		logic rdig;
		logic [31:0] rval;
		logic [3:0] pw;
		logic [3:0] dig;
		logic started;
		logic rsp_v;
		logic [7:0] rsp;
		logic aw_v;
		logic [7:0] awa;
		logic w_v;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
	} msc_state_t;

	msc_state_t q, d;
	logic tick, open, dwell_gov, leave_ok, acc, exec_start;

	function automatic logic [31:0] pow10(input logic [3:0] p);
		case (p)
			4'd0: pow10 = 32'd1;
			4'd1: pow10 = 32'd10;
			4'd2: pow10 = 32'd100;
			4'd3: pow10 = 32'd1000;
			4'd4: pow10 = 32'd10000;
			4'd5: pow10 = 32'd100000;
			4'd6: pow10 = 32'd1000000;
			4'd7: pow10 = 32'd10000000;
			default: pow10 = 32'd100000000;
		endcase
	endfunction : pow10

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == REG_CMD) || (a == REG_RSP) || (a == REG_STAT) ||
			(a == REG_MASK) || (a == REG_STATE);
	endfunction : mapped

	assign tick = (q.div == 32'(MS_CYCLES - 1));
	assign open = (s_meter >= q.sql);
	assign dwell_gov = (q.dwell != 32'd0) && (q.dwell < q.deadset);
	assign leave_ok = dwell_gov ? (q.tmr >= q.dwell) : (!open && q.dead >= q.deadset);
	assign acc = q.ovr || (address_switch_bank == ADDR_ALL) ||
		(q.has_addr && q.addr == address_switch_bank);

	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] clr;
		logic byte_v;
		logic [7:0] b;
		logic err;
		logic reply;
		logic [31:0] rv_val;
		ev = '0;
		clr = '0;
		byte_v = 1'b0;
		b = 8'h00;
		err = 1'b0;
		reply = 1'b0;
		rv_val = 32'd0;
		exec_start = 1'b0;
		d = q;
		// ------------------------------------------------------------
		// Millisecond tick and squelch
		// ------------------------------------------------------------
		d.div = tick ? 32'd0 : q.div + 32'd1;
		d.mute = !open;
		// ------------------------------------------------------------
		// Scan sequencer
		// ------------------------------------------------------------
		unique case (q.scan)
			SC_MANUAL, SC_PAUSED: begin
			end
			SC_HOLD: begin
				if (q.tmr >= q.hold) begin
					d.scan = SC_GAZE;
					d.tmr = 32'd0;
				end else if (tick) begin
					d.tmr = q.tmr + 32'd1;
				end
			end
			SC_GAZE: begin
				if (open) begin
					d.scan = SC_ACTIVE;
					d.tmr = 32'd0;
					d.dead = 32'd0;
					ev[IRQ_ACT] = 1'b1;
				end else if (q.tmr >= q.gaze) begin
					d.scan = SC_HOLD;
					d.tmr = 32'd0;
					d.chan = (q.chan == CH_LAST) ? CH_FIRST : q.chan + 10'd1;
				end else if (tick) begin
					d.tmr = q.tmr + 32'd1;
				end
			end
			SC_ACTIVE: begin
				if (leave_ok) begin
					d.scan = SC_HOLD;
					d.tmr = 32'd0;
					d.chan = (q.chan == CH_LAST) ? CH_FIRST : q.chan + 10'd1;
				end else begin
					if (tick) begin
						d.tmr = q.tmr + 32'd1;
					end
					// Dead time restarts whenever squelch reopens
					d.dead = open ? 32'd0 : (tick ? q.dead + 32'd1 : q.dead);
				end
			end
		endcase
		// ------------------------------------------------------------
		// AXI4-Lite slave
		// ------------------------------------------------------------
		if (q.bv && axi_req.bready) begin
			d.bv = 1'b0;
		end
		if (q.rv && axi_req.rready) begin
			d.rv = 1'b0;
		end
		if (axi_req.awvalid && !q.aw_v) begin
			d.aw_v = 1'b1;
			d.awa = axi_req.awaddr;
		end
		if (axi_req.wvalid && !q.w_v) begin
			d.w_v = 1'b1;
			d.wd = axi_req.wdata;
			d.ws = axi_req.wstrb;
		end
		// Command bytes stall while a reply is still being produced
		if (q.aw_v && q.w_v && !q.bv && !(q.awa == REG_CMD && q.ps == PS_REPLY)) begin
			d.aw_v = 1'b0;
			d.w_v = 1'b0;
			d.bv = 1'b1;
			d.br = mapped(q.awa) ? RESP_OKAY : RESP_SLVERR;
			if (q.ws[0]) begin
				if (q.awa == REG_CMD) begin
					byte_v = 1'b1;
					b = q.wd[7:0];
				end else if (q.awa == REG_STAT) begin
					clr = q.wd[IRQ_W-1:0];
				end else if (q.awa == REG_MASK) begin
					d.mask = q.wd[IRQ_W-1:0];
				end
			end
		end
		if (axi_req.arvalid && !q.rv) begin
			d.rv = 1'b1;
			d.rr = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
			d.rd = 32'd0;
			if (axi_req.araddr == REG_CMD) begin
				d.rd = {31'd0, q.ps == PS_REPLY};
			end else if (axi_req.araddr == REG_RSP) begin
				d.rd = {23'd0, q.rsp_v, q.rsp};
				d.rsp_v = 1'b0;
			end else if (axi_req.araddr == REG_STAT) begin
				d.rd = {{(32-IRQ_W){1'b0}}, q.stat};
			end else if (axi_req.araddr == REG_MASK) begin
				d.rd = {{(32-IRQ_W){1'b0}}, q.mask};
			end else if (axi_req.araddr == REG_STATE) begin
				d.rd = {9'd0, s_meter, 1'b0, q.ovr, q.mute, q.scan, q.chan};
			end
		end
		// ------------------------------------------------------------
		// Command parser
		// ------------------------------------------------------------
		if (byte_v) begin
			if (b == ASC_CR) begin
				d.ps = PS_IDLE;
				d.has_addr = 1'b0;
				if (q.ps == PS_ARG && acc) begin
					unique case (q.code)
						CODE_SQL: begin
							if (q.get) begin
								reply = 1'b1;
								rv_val = {25'd0, q.sql};
							end else if (q.val > SQL_MAX) begin
								err = 1'b1;
							end else begin
								d.sql = q.val[6:0];
							end
						end
						CODE_STR: begin
							err = !q.get;
							reply = q.get;
							rv_val = {25'd0, s_meter};
						end
						CODE_DWELL: begin
							if (q.get) begin
								reply = 1'b1;
								rv_val = q.dwell;
							end else if (q.val > GAZE_MAX) begin
								err = 1'b1;
							end else begin
								d.dwell = q.val;
							end
						end
						CODE_DEAD: begin
							if (q.get) begin
								reply = 1'b1;
								rv_val = q.deadset;
							end else if (q.val > DEAD_MAX) begin
								err = 1'b1;
							end else begin
								d.deadset = q.val;
							end
						end
						CODE_GAZE: begin
							if (q.get) begin
								reply = 1'b1;
								rv_val = q.gaze;
							end else if (q.val > GAZE_MAX) begin
								err = 1'b1;
							end else begin
								d.gaze = q.val;
							end
						end
						CODE_HOLD: begin
							if (q.get) begin
								reply = 1'b1;
								rv_val = q.hold;
							end else if (q.val > HOLD_MAX) begin
								err = 1'b1;
							end else begin
								d.hold = q.val;
							end
						end
						CODE_OVR_OFF: begin
							err = q.get;
							if (!q.get) begin
								d.ovr = 1'b0;
							end
						end
						CODE_OVR_ON: begin
							err = q.get;
							if (!q.get) begin
								d.ovr = 1'b1;
							end
						end
						CODE_RESET: begin
							err = q.get;
							if (!q.get) begin
								d.ovr = 1'b0;
								d.scan = SC_MANUAL;
								d.chan = q.chan;
								d.sql = SQL_DEF;
								d.dwell = DWELL_DEF_MS;
								d.deadset = DEAD_DEF_MS;
								d.gaze = GAZE_DEF_MS;
								d.hold = HOLD_DEF_MS;
							end
						end
						CODE_SCAN: begin
							if (q.get) begin
								err = 1'b1;
							end else if (q.argc == SC_ARG_START) begin
								exec_start = 1'b1;
								if (!chan_any_prog) begin
									err = 1'b1;
								end else begin
									d.scan = SC_HOLD;
									d.chan = CH_FIRST;
									d.tmr = 32'd0;
								end
							end else if (q.argc == SC_ARG_HALT) begin
								d.scan = SC_MANUAL;
								// Halt outranks a channel step falling in the same cycle
								d.chan = q.chan;
							end else if (q.argc == SC_ARG_PAUSE) begin
								if (q.scan != SC_MANUAL && q.scan != SC_PAUSED) begin
									d.scan = SC_PAUSED;
									d.chan = q.chan;
								end
							end else if (q.argc == SC_ARG_RESUME) begin
								if (q.scan == SC_PAUSED) begin
									d.scan = SC_HOLD;
									d.tmr = 32'd0;
								end
							end else begin
								err = 1'b1;
							end
						end
						default: err = 1'b1;
					endcase
				end
			end else begin
				unique case (q.ps)
					PS_IDLE: begin
						if (b[ADDR_FLAG]) begin
							d.has_addr = 1'b1;
							d.addr = b[4:0];
						end else if (b == ASC_SET || b == ASC_GET) begin
							d.get = (b == ASC_GET);
							d.ps = PS_CODE1;
						end
					end
					PS_CODE1: begin
						d.code = {b, 8'h00};
						d.ps = PS_CODE2;
					end
					PS_CODE2: begin
						d.code = {q.code[15:8], b};
						d.ps = PS_ARG;
						d.val = 32'd0;
						d.argc = 8'h00;
					end
					PS_ARG: begin
						if (b >= ASC_0 && b <= ASC_9) begin
							d.val = q.val * 32'd10 + {28'd0, b[3:0]};
						end else begin
							d.argc = b;
						end
					end
					PS_REPLY: begin
					end
				endcase
			end
		end
		if (err || reply) begin
			d.ps = PS_REPLY;
			d.rp = RP_C1;
			d.rcode = err ? CODE_ERR : q.code;
			d.rdig = reply;
			d.rval = rv_val;
			d.pw = 4'd8;
			d.dig = 4'd0;
			d.started = 1'b0;
			ev[IRQ_ERR] = err;
		end
		// ------------------------------------------------------------
		// Reply generator, one byte per free response slot
		// ------------------------------------------------------------
		if (q.ps == PS_REPLY && !q.rsp_v) begin
			unique case (q.rp)
				RP_C1: begin
					d.rsp = q.rcode[15:8];
					d.rsp_v = 1'b1;
					d.rp = RP_C2;
				end
				RP_C2: begin
					d.rsp = q.rcode[7:0];
					d.rsp_v = 1'b1;
					d.rp = q.rdig ? RP_DIG : RP_CR;
				end
				RP_DIG: begin
					if (q.rval >= pow10(q.pw)) begin
						d.rval = q.rval - pow10(q.pw);
						d.dig = q.dig + 4'd1;
					end else begin
						// Leading zeros dropped, last digit always sent
						if (q.dig != 4'd0 || q.started || q.pw == 4'd0) begin
							d.rsp = ASC_0 + {4'd0, q.dig};
							d.rsp_v = 1'b1;
							d.started = 1'b1;
						end
						d.dig = 4'd0;
						if (q.pw == 4'd0) begin
							d.rp = RP_CR;
						end else begin
							d.pw = q.pw - 4'd1;
						end
					end
				end
				RP_CR: begin
					d.rsp = ASC_CR;
					d.rsp_v = 1'b1;
					d.ps = PS_IDLE;
				end
			endcase
		end
		ev[IRQ_RSP] = d.rsp_v && !q.rsp_v;
		// Hardware set wins over a same-cycle clear
		d.stat = (q.stat & ~clr) | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.scan <= SC_MANUAL;
			q.ps <= PS_IDLE;
			q.rp <= RP_C1;
			q.mute <= 1'b1;
			q.sql <= SQL_DEF;
			q.dwell <= DWELL_DEF_MS;
			q.deadset <= DEAD_DEF_MS;
			q.gaze <= GAZE_DEF_MS;
			q.hold <= HOLD_DEF_MS;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp = '{awready: !q.aw_v, wready: !q.w_v, bresp: q.br, bvalid: q.bv,
		arready: !q.rv, rdata: q.rd, rresp: q.rr, rvalid: q.rv};
	assign irq = |(q.stat & q.mask);
	assign scan_chan = q.chan;
	assign scan_mode = q.scan;
	assign audio_mute = q.mute;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chan_range_a: assert property (q.chan <= CH_LAST)
		else $error("scan channel out of range");
	start_noprog_a: assert property (exec_start && !chan_any_prog && q.scan == SC_MANUAL
		&& !q.rsp_v |=> q.scan == SC_MANUAL ##1 q.rsp_v && q.rsp == CODE_ERR[15:8])
		else $error("start without programmed channel left manual mode");
	halt_keep_a: assert property ((q.scan != SC_MANUAL ##1 q.scan == SC_MANUAL)
		|-> q.chan == $past(q.chan))
		else $error("halt changed channel");
	pause_only_a: assert property (q.scan == SC_MANUAL |=> q.scan != SC_PAUSED)
		else $error("pause taken outside scan");
	resume_only_a: assert property (q.scan == SC_PAUSED
		|=> q.scan inside {SC_PAUSED, SC_HOLD, SC_MANUAL})
		else $error("bad exit from paused");
	mute_cmp_a: assert property ($past(aresetn) |-> audio_mute == !$past(open))
		else $error("mute does not follow squelch");
	leave_active_a: assert property ((q.scan == SC_ACTIVE && !exec_start ##1 q.scan == SC_HOLD)
		|-> $past(leave_ok) && q.chan != $past(q.chan))
		else $error("active channel left before timer");
	holdoff_wait_a: assert property ((q.scan == SC_HOLD ##1 q.scan == SC_GAZE)
		|-> $past(q.tmr) >= q.hold)
		else $error("activity judged before hold-off");
	addr_gate_a: assert property ((q.ps == PS_ARG ##1 q.ps == PS_REPLY) |-> $past(acc))
		else $error("reply to foreign address");
	irq_level_a: assert property ($rose(q.ps == PS_REPLY) && q.rcode == CODE_ERR && q.mask[IRQ_ERR]
		|-> irq)
		else $error("error reply raised no interrupt");

	active_seen_c: cover property (q.scan == SC_GAZE ##1 q.scan == SC_ACTIVE);
	pause_resume_c: cover property (q.scan == SC_PAUSED ##[1:1000] q.scan == SC_HOLD);
	error_reply_c: cover property (q.rsp_v && q.rsp == CODE_ERR[15:8]);
endmodule : msc_scan_ctrl
`default_nettype wire

// ---- sim/msc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module msc_host (
	input wire logic aclk,
	output var msc_pkg::msc_axi_req_t axi_req,
	input wire msc_pkg::msc_axi_rsp_t axi_rsp
);
	import msc_pkg::*;
	// ----------------------------------------------------------------
	// Host side of the register bus
	// ----------------------------------------------------------------
	// Response readies stay high: avoids a double drive between calls
	initial begin
		axi_req = '0;
		axi_req.bready = 1'b1;
		axi_req.rready = 1'b1;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
		end while (axi_rsp.bvalid !== 1'b1);
		resp = axi_rsp.bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
		end while (axi_rsp.rvalid !== 1'b1);
		d = axi_rsp.rdata;
		resp = axi_rsp.rresp;
	endtask : rd
endmodule : msc_host
`default_nettype wire

// ---- sim/memory_scan_squelch_control_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module memory_scan_squelch_control_test;
	import msc_pkg::*;
	localparam int unsigned MS = 10;
	logic aclk, aresetn, irq, audio_mute, chan_any_prog;
	logic [4:0] address_switch_bank;
	logic [6:0] s_meter;
	logic [9:0] scan_chan;
	logic [2:0] scan_mode;
	msc_axi_req_t axi_req;
	msc_axi_rsp_t axi_rsp;
	int failures = 0;
	int checked = 0;
	int n;
	logic [9:0] c;
	logic [31:0] v;
	logic [1:0] r;

	msc_scan_ctrl #(.MS_CYCLES(MS)) i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
		.axi_rsp(axi_rsp), .irq(irq), .address_switch_bank(address_switch_bank),
		.s_meter(s_meter), .chan_any_prog(chan_any_prog), .scan_chan(scan_chan),
		.scan_mode(scan_mode), .audio_mute(audio_mute));
	msc_host i_host (.aclk(aclk), .axi_req(axi_req), .axi_rsp(axi_rsp));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic ckm(input msc_scan_t m);
		chk(32'(scan_mode), 32'(m));
	endtask : ckm

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask : cyc

	// Address byte only when its flag bit is set
	task automatic send(input logic [7:0] ad, input string s);
		logic [1:0] rr;
		if (ad[7]) i_host.wr(REG_CMD, 32'(ad), rr);
		for (int i = 0; i < s.len(); i++) i_host.wr(REG_CMD, 32'(s[i]), rr);
		i_host.wr(REG_CMD, 32'(ASC_CR), rr);
	endtask : send

	task automatic reply(input string e);
		logic [31:0] d;
		logic [1:0] rr;
		for (int i = 0; i <= e.len(); i++) begin
			d = '0;
			while (d[8] !== 1'b1) i_host.rd(REG_RSP, d, rr);
			chk(32'(d[7:0]), (i < e.len()) ? 32'(e[i]) : 32'(ASC_CR));
		end
	endtask : reply

	// A dropped or ignored command leaves the reply register empty
	task automatic noreply;
		logic [31:0] d;
		logic [1:0] rr;
		cyc(80);
		i_host.rd(REG_RSP, d, rr);
		chk(32'(d[8]), 32'h0);
	endtask : noreply

	task automatic wmode(input msc_scan_t m);
		int k;
		k = 0;
		while (scan_mode !== m && k < 400) begin
			@(posedge aclk);
			k++;
		end
		ckm(m);
	endtask : wmode

	task automatic wchan(input int lim, output int k);
		logic [9:0] c0;
		c0 = scan_chan;
		k = 0;
		while (scan_chan === c0 && k < lim) begin
			@(posedge aclk);
			k++;
		end
	endtask : wchan

	task complete_run;
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	// Whole sequence needs roughly 2k cycles
	initial begin
		#300000;
		failures++;
		complete_run;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		address_switch_bank = 5'h1f;
		s_meter = 7'h00;
		chan_any_prog = 1'b0;
		cyc(16);
		aresetn <= 1'b1;
		cyc(2);
		ckm(SC_MANUAL);
		chk(32'(irq), 32'h0);
		i_host.rd(8'h14, v, r);
		chk({v[29:0], r}, {30'h0, RESP_SLVERR});
		i_host.wr(8'h20, 32'h1, r);
		chk(32'(r), 32'(RESP_SLVERR));
		send(8'h00, "?T2");
		reply("T28000");
		send(8'h00, "?T4");
		reply("T450");
		s_meter <= 7'h5d;
		send(8'h00, "?S3");
		reply("S393");
		i_host.rd(REG_STATE, v, r);
		chk(32'(v[22:16]), 32'h5d);
		send(8'h00, "*S150");
		s_meter <= 7'h31;
		cyc(4);
		chk(32'(audio_mute), 32'h1);
		s_meter <= 7'h32;
		cyc(4);
		chk(32'(audio_mute), 32'h0);
		send(8'h00, "*S1128");
		reply("ER");
		chk(32'(irq), 32'h0);
		i_host.wr(REG_MASK, 32'h2, r);
		i_host.rd(REG_MASK, v, r);
		chk(v, 32'h2);
		cyc(2);
		chk(32'(irq), 32'h1);
		i_host.wr(REG_STAT, 32'h2, r);
		cyc(2);
		chk(32'(irq), 32'h0);
		send(8'h00, "*P4S");
		reply("ER");
		ckm(SC_MANUAL);
		chk(32'(irq), 32'h1);
		send(8'h00, "*P4P");
		noreply();
		ckm(SC_MANUAL);
		send(8'h00, "*P4R");
		noreply();
		ckm(SC_MANUAL);
		send(8'h00, "*P4X");
		reply("ER");
		// Squelch shut at top level so no channel becomes active
		chan_any_prog <= 1'b1;
		s_meter <= 7'h00;
		send(8'h00, "*S1127");
		send(8'h00, "*T42");
		send(8'h00, "*T33");
		send(8'h00, "?T3");
		reply("T33");
		send(8'h00, "*P4S");
		cyc(3);
		ckm(SC_HOLD);
		chk(32'(scan_chan), 32'h0);
		wchan(200, n);
		wchan(200, n);
		chk(32'(n >= 3 * MS && n <= 5 * MS + 8), 32'h1);
		cyc(3);
		ckm(SC_HOLD);
		send(8'h00, "*P4P");
		cyc(2);
		ckm(SC_PAUSED);
		c = scan_chan;
		send(8'h00, "*P4P");
		cyc(100);
		ckm(SC_PAUSED);
		chk(32'(scan_chan), 32'(c));
		send(8'h00, "*P4R");
		cyc(2);
		ckm(SC_HOLD);
		chk(32'(scan_chan), 32'(c));
		cyc(25);
		c = scan_chan;
		send(8'h00, "*P4H");
		cyc(2);
		ckm(SC_MANUAL);
		cyc(100);
		chk(32'(scan_chan), 32'(c));
		// Open squelch: dwell 3 ms against dead 5 ms
		send(8'h00, "*S110");
		s_meter <= 7'h14;
		send(8'h00, "*T13");
		send(8'h00, "*T25");
		send(8'h00, "*P4S");
		wmode(SC_ACTIVE);
		chk(32'(scan_chan), 32'h0);
		wchan(200, n);
		chk(32'(n >= 2 * MS && n <= 3 * MS + 8), 32'h1);
		send(8'h00, "*T10");
		wmode(SC_ACTIVE);
		wchan(300, n);
		chk(32'(n), 32'd300);
		s_meter <= 7'h00;
		wchan(300, n);
		chk(32'(n >= 4 * MS && n <= 5 * MS + 10), 32'h1);
		send(8'h00, "*P4H");
		// Addressing from the switch bank
		address_switch_bank <= 5'h05;
		cyc(2);
		send(8'h00, "?S1");
		noreply();
		send(8'h94, "?S1");
		noreply();
		send(8'h85, "?S1");
		reply("S110");
		send(8'h85, "*U2");
		send(8'h00, "?S1");
		reply("S110");
		i_host.rd(REG_STATE, v, r);
		chk(32'(v[14]), 32'h1);
		send(8'h00, "*U1");
		send(8'h00, "?S1");
		noreply();
		send(8'h85, "*U2");
		send(8'h00, "*C9");
		send(8'h00, "?S1");
		noreply();
		send(8'h85, "?T2");
		reply("T28000");
		address_switch_bank <= 5'h1f;
		cyc(2);
		send(8'h00, "?S1");
		reply("S10");
		complete_run;
	end
endmodule : memory_scan_squelch_control_test
`default_nettype wire
